// >>> rtl/cgk_pkg.sv
// shared constants, types and helpers for the chroma gain and colour kill block
package cgk_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LEVEL     = 8'h01;
  localparam logic [7:0] ADDR_KILL_EN   = 8'h2b;
  localparam logic [7:0] ADDR_MODE      = 8'h2c;
  localparam logic [7:0] ADDR_GAIN_HI   = 8'h2d;
  localparam logic [7:0] ADDR_GAIN_LO   = 8'h2e;
  localparam logic [7:0] ADDR_KILL_THR  = 8'h3d;
  localparam logic [7:0] ADDR_SHARP_EN  = 8'h4d;
  localparam logic [7:0] ADDR_SHARP_THR = 8'h4e;
  // field positions
  localparam int LEVEL_BIT    = 5;
  localparam int KILL_EN_BIT  = 6;
  localparam int SPEED_LSB    = 6;
  localparam int THR_LSB      = 4;
  localparam int SHARP_EN_BIT = 0;
  // reset values
  localparam logic       RST_LEVEL     = 1'h0;
  localparam logic       RST_KILL_EN   = 1'h1;
  localparam logic [1:0] RST_MODE      = 2'h2;
  localparam logic [1:0] RST_SPEED     = 2'h3;
  localparam logic [11:0] RST_GAIN     = 12'h400;
  localparam logic [2:0] RST_KILL_THR  = 3'h4;
  localparam logic       RST_SHARP_EN  = 1'h0;
  localparam logic [7:0] RST_SHARP_THR = 8'h08;
  // gain code is a fraction with this many bits below the point
  localparam int          GAIN_FRAC = 10;
  localparam logic [11:0] GAIN_MAX  = 12'hfff;
  localparam logic [11:0] GAIN_MIN  = 12'h001;
  // gain modes
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_LUMA   = 2'h1;
  localparam logic [1:0] MODE_AUTO   = 2'h2;
  localparam logic [1:0] MODE_FREEZE = 2'h3;
  // tracking speeds
  localparam logic [1:0] SPEED_SLOW  = 2'h0;
  localparam logic [1:0] SPEED_MED   = 2'h1;
  localparam logic [1:0] SPEED_FAST  = 2'h2;
  // input families
  localparam logic [1:0] FMT_QAM  = 2'h0;
  localparam logic [1:0] FMT_FM   = 2'h1;
  localparam logic [1:0] FMT_COMP = 2'h2;
  // loop time constants; one step per period walks the full gain range
  localparam int CLK_KHZ    = 125000;
  localparam int TC_SLOW_MS = 2000;
  localparam int TC_MED_MS  = 1000;
  localparam int TC_FAST_MS = 200;
  localparam int GAIN_STEPS = 4096;
  localparam int SLOW_CYC   = TC_SLOW_MS * CLK_KHZ / GAIN_STEPS;
  localparam int MED_CYC    = TC_MED_MS * CLK_KHZ / GAIN_STEPS;
  localparam int FAST_CYC   = TC_FAST_MS * CLK_KHZ / GAIN_STEPS;
  localparam logic [9:0] ADAPT_ERR_MV    = 10'h028;
  localparam logic [9:0] BURST_TARGET_MV = 10'h096;
  // component level sets in mV
  localparam logic [9:0] LUMA_BRD_MV  = 10'h2ca;
  localparam logic [9:0] CDIFF_BRD_MV = 10'h1d3;
  localparam logic [9:0] SYNC_BRD_MV  = 10'h11e;
  localparam logic [9:0] LUMA_STD_MV  = 10'h2bc;
  localparam logic [9:0] CDIFF_STD_MV = 10'h15e;
  localparam logic [9:0] SYNC_STD_MV  = 10'h12c;
  // colour kill: line count and thresholds in tenths of a percent
  localparam logic [6:0] KILL_LAST_LINE = 7'h7f;
  localparam logic [2:0] THR_RESERVED   = 3'h7;
  localparam logic [2:0] THR_FM_NONE    = 3'h0;
  localparam logic [6:0][9:0] QAM_THR = {10'h140, 10'h0a0, 10'h055,
    10'h028, 10'h019, 10'h00f, 10'h005};
  localparam logic [6:0][9:0] FM_THR = {10'h140, 10'h096, 10'h05f,
    10'h050, 10'h046, 10'h032, 10'h000};

  // one chroma sample with its qualifier
  typedef struct packed {
    logic              valid;
    logic signed [9:0] data;
  } cgk_samp_t;

  // clamp a wide signed value to the sample range
  function automatic logic signed [9:0] sat10(input logic signed [23:0] v);
    if (v > 24'sh0001ff) begin
      return 10'sh1ff;
    end
    if (v < -24'sh000200) begin
      return -10'sh200;
    end
    return v[9:0];
  endfunction
endpackage

// >>> rtl/cgk_edge_sharpen.sv
// chroma edge sharpening stage with amplitude threshold
`timescale 1ns/1ns
module cgk_edge_sharpen (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // control
  input  wire logic              en_i,
  input  wire logic [7:0]        thr_i,
  // samples
  input  wire cgk_pkg::cgk_samp_t in_i,
  output cgk_pkg::cgk_samp_t     out_o
);
  logic signed [9:0]  prev;
  logic signed [10:0] diff;
  logic        [10:0] mag;

  // step between neighbouring samples
  always_comb begin
    diff = 11'(in_i.data) - 11'(prev);
    mag  = diff[10] ? 11'(-diff) : diff;
  end

  // remember the last sample
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev <= '0;
    end else if (in_i.valid) begin
      prev <= in_i.data;
    end
  end

  // steepen only large steps so noise is left alone
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      out_o <= '0;
    end else begin
      out_o.valid <= in_i.valid;
      if (en_i && mag > {3'h0, thr_i}) begin
        out_o.data <= cgk_pkg::sat10(24'(in_i.data) + 24'(diff >>> 1));
      end else begin
        out_o.data <= in_i.data;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_sharpen_off_pass: assert property (
    !en_i && in_i.valid |=> out_o.data == $past(in_i.data))
    else $error("disabled sharpener altered a sample");
  chk_small_step_pass: assert property (
    mag <= {3'h0, thr_i} && in_i.valid |=> out_o.data == $past(in_i.data))
    else $error("step below threshold was altered");
  cov_sharpen_edge: cover property (en_i && in_i.valid
    && mag > {3'h0, thr_i});
endmodule

// >>> rtl/cgk_chroma_ctrl.sv
// chroma gain, colour kill and edge sharpening control top
`timescale 1ns/1ns
// How it works
// - gain mode 00 manual, 01 luma gain, 10 burst tracking, 11 freeze
// - tracking speed only matters while the gain mode is burst tracking
// - speed 00 slow 2 s, 10 fast 0.2 s, 11 adaptive by default
// - component tracking aims at the broadcast or standards level set
// - writes to the gain pair store a manual gain used in manual mode
// - reads of the gain pair return the gain actually in use
// - the gain code divided by 1024 is the linear chroma gain
// - a kill enable bit switches colour kill, enabled after reset
// - 128 lines below threshold turn colour off
// - 128 lines above threshold turn colour back on
// - component inputs are never colour killed
// - frequency modulated thresholds 000 none up to 110 32 percent
// - quadrature thresholds 000 to 110 from 0.5 up to 32 percent
// - edge sharpening touches only steps larger than the threshold
// - an enable bit gates sharpening, off after reset
module cgk_chroma_ctrl #(
  parameter int SLOW_CYC = cgk_pkg::SLOW_CYC,
  parameter int MED_CYC  = cgk_pkg::MED_CYC,
  parameter int FAST_CYC = cgk_pkg::FAST_CYC
) (
  // clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RST_N_I,
  // register port
  input  wire logic [7:0]         ADDR_I,
  input  wire logic [7:0]         WDATA_I,
  input  wire logic               WR_I,
  input  wire logic               RD_I,
  output logic [7:0]              RDATA_O,
  // video side
  input  wire cgk_pkg::cgk_samp_t SAMPLE_I,
  input  wire logic               LINE_I,
  input  wire logic [9:0]         BURST_PCT_I,
  input  wire logic [9:0]         CHROMA_AMP_I,
  input  wire logic [11:0]        LUMA_GAIN_I,
  input  wire logic [1:0]         INPUT_FMT_I,
  // results
  output cgk_pkg::cgk_samp_t      SAMPLE_O,
  output logic                    COLOR_KILLED_O,
  output logic [9:0]              LUMA_TARGET_O,
  output logic [9:0]              CDIFF_TARGET_O,
  output logic [9:0]              SYNC_TARGET_O
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic        level_broadcast;
  logic        color_suppress_enable;
  logic [1:0]  chroma_gain_mode;
  logic [1:0]  chroma_gain_tracking_speed;
  logic [11:0] chroma_gain_manual;
  logic [2:0]  color_suppress_threshold;
  logic        chroma_edge_sharpen_enable;
  logic [7:0]  sharpen_thr;
  logic [11:0] chroma_gain_active;
  logic [11:0] auto_gain;
  logic [9:0]  amp_seen;
  logic [19:0] rate_cnt;
  logic        step_en;
  logic [9:0]  agc_target;
  logic [9:0]  amp_err;
  logic [1:0]  speed_used;
  logic [19:0] step_lim;
  logic [6:0]  kill_cnt;
  logic        killed;
  logic        kill_armed;
  logic [9:0]  kill_thr;
  logic        below;
  logic [11:0] next_gain;
  cgk_pkg::cgk_samp_t gained;

  wire is_comp = (INPUT_FMT_I == cgk_pkg::FMT_COMP);
  wire wr_hit  = WR_I;

  // software writes
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      level_broadcast            <= cgk_pkg::RST_LEVEL;
      color_suppress_enable      <= cgk_pkg::RST_KILL_EN;
      chroma_gain_mode           <= cgk_pkg::RST_MODE;
      chroma_gain_tracking_speed <= cgk_pkg::RST_SPEED;
      chroma_gain_manual         <= cgk_pkg::RST_GAIN;
      color_suppress_threshold   <= cgk_pkg::RST_KILL_THR;
      chroma_edge_sharpen_enable <= cgk_pkg::RST_SHARP_EN;
      sharpen_thr                <= cgk_pkg::RST_SHARP_THR;
    end else if (wr_hit) begin
      unique case (ADDR_I)
        cgk_pkg::ADDR_LEVEL:
          level_broadcast <= WDATA_I[cgk_pkg::LEVEL_BIT];
        cgk_pkg::ADDR_KILL_EN:
          color_suppress_enable <= WDATA_I[cgk_pkg::KILL_EN_BIT];
        cgk_pkg::ADDR_MODE:
          chroma_gain_mode <= WDATA_I[1:0];
        cgk_pkg::ADDR_GAIN_HI: begin
          chroma_gain_tracking_speed <=
            WDATA_I[cgk_pkg::SPEED_LSB +: 2];
          chroma_gain_manual[11:8] <= WDATA_I[3:0];
        end
        cgk_pkg::ADDR_GAIN_LO:
          chroma_gain_manual[7:0] <= WDATA_I;
        cgk_pkg::ADDR_KILL_THR:
          color_suppress_threshold <= WDATA_I[cgk_pkg::THR_LSB +: 3];
        cgk_pkg::ADDR_SHARP_EN:
          chroma_edge_sharpen_enable <= WDATA_I[cgk_pkg::SHARP_EN_BIT];
        cgk_pkg::ADDR_SHARP_THR:
          sharpen_thr <= WDATA_I;
        default: ;
      endcase
    end
  end

  // read data stands for exactly one cycle after the strobe
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      RDATA_O <= 8'h00;
    end else if (!RD_I) begin
      RDATA_O <= 8'h00;
    end else begin
      unique case (ADDR_I)
        cgk_pkg::ADDR_LEVEL:
          RDATA_O <= 8'(level_broadcast) << cgk_pkg::LEVEL_BIT;
        cgk_pkg::ADDR_KILL_EN:
          RDATA_O <= 8'(color_suppress_enable) << cgk_pkg::KILL_EN_BIT;
        cgk_pkg::ADDR_MODE:
          RDATA_O <= {6'h00, chroma_gain_mode};
        cgk_pkg::ADDR_GAIN_HI:
          RDATA_O <= {chroma_gain_tracking_speed, 2'h0,
                      chroma_gain_active[11:8]};
        cgk_pkg::ADDR_GAIN_LO:
          RDATA_O <= chroma_gain_active[7:0];
        cgk_pkg::ADDR_KILL_THR:
          RDATA_O <= {1'h0, color_suppress_threshold, 4'h0};
        cgk_pkg::ADDR_SHARP_EN:
          RDATA_O <= {7'h00, chroma_edge_sharpen_enable};
        cgk_pkg::ADDR_SHARP_THR:
          RDATA_O <= sharpen_thr;
        default:
          RDATA_O <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level targets handed to the gain loops
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      LUMA_TARGET_O  <= cgk_pkg::LUMA_STD_MV;
      CDIFF_TARGET_O <= cgk_pkg::CDIFF_STD_MV;
      SYNC_TARGET_O  <= cgk_pkg::SYNC_STD_MV;
    end else if (level_broadcast) begin
      LUMA_TARGET_O  <= cgk_pkg::LUMA_BRD_MV;
      CDIFF_TARGET_O <= cgk_pkg::CDIFF_BRD_MV;
      SYNC_TARGET_O  <= cgk_pkg::SYNC_BRD_MV;
    end else begin
      LUMA_TARGET_O  <= cgk_pkg::LUMA_STD_MV;
      CDIFF_TARGET_O <= cgk_pkg::CDIFF_STD_MV;
      SYNC_TARGET_O  <= cgk_pkg::SYNC_STD_MV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic loop: target, error and step rate
  always_comb begin
    agc_target = is_comp ? CDIFF_TARGET_O : cgk_pkg::BURST_TARGET_MV;
    amp_err = (amp_seen > agc_target) ? amp_seen - agc_target
                                      : agc_target - amp_seen;
    speed_used = chroma_gain_tracking_speed;
    if (chroma_gain_tracking_speed == 2'h3) begin
      speed_used = (amp_err > cgk_pkg::ADAPT_ERR_MV) ? cgk_pkg::SPEED_FAST
                                                     : cgk_pkg::SPEED_SLOW;
    end
    // cycles between two loop steps for the speed in use
    unique case (speed_used)
      cgk_pkg::SPEED_SLOW: step_lim = 20'(SLOW_CYC);
      cgk_pkg::SPEED_MED:  step_lim = 20'(MED_CYC);
      default:             step_lim = 20'(FAST_CYC);
    endcase
  end

  // amplitude measured on the last line
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      amp_seen <= cgk_pkg::BURST_TARGET_MV;
    end else if (LINE_I) begin
      amp_seen <= CHROMA_AMP_I;
    end
  end

  // step pacing, only running while the loop tracks
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || chroma_gain_mode != cgk_pkg::MODE_AUTO) begin
      rate_cnt <= 20'h00000;
      step_en  <= 1'b0;
    end else if (rate_cnt >= step_lim - 20'h00001) begin
      rate_cnt <= 20'h00000; // restart so each period gives one step
      step_en  <= 1'b1;
    end else begin
      rate_cnt <= rate_cnt + 20'h00001;
      step_en  <= 1'b0;
    end
  end

  // loop gain walks one code toward the target per step
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      auto_gain <= cgk_pkg::RST_GAIN;
    end else if (chroma_gain_mode == cgk_pkg::MODE_AUTO && step_en) begin
      if (amp_seen < agc_target && auto_gain != cgk_pkg::GAIN_MAX) begin
        auto_gain <= auto_gain + 12'h001;
      end else if (amp_seen > agc_target
                   && auto_gain != cgk_pkg::GAIN_MIN) begin
        auto_gain <= auto_gain - 12'h001;
      end
    end
  end

  // gain in use for the selected mode
  always_comb begin
    unique case (chroma_gain_mode)
      cgk_pkg::MODE_MANUAL: next_gain = chroma_gain_manual;
      cgk_pkg::MODE_LUMA:   next_gain = LUMA_GAIN_I;
      cgk_pkg::MODE_AUTO:   next_gain = auto_gain;
      cgk_pkg::MODE_FREEZE: next_gain = auto_gain;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      chroma_gain_active <= cgk_pkg::RST_GAIN;
    end else begin
      chroma_gain_active <= next_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // colour kill threshold and line classification
  always_comb begin
    kill_armed = color_suppress_enable && !is_comp
                 && color_suppress_threshold != cgk_pkg::THR_RESERVED;
    if (INPUT_FMT_I == cgk_pkg::FMT_FM) begin
      kill_thr = cgk_pkg::FM_THR[color_suppress_threshold];
      if (color_suppress_threshold == cgk_pkg::THR_FM_NONE) begin
        kill_armed = 1'b0;
      end
    end else begin
      kill_thr = cgk_pkg::QAM_THR[color_suppress_threshold];
    end
    below = BURST_PCT_I < kill_thr;
  end

  // consecutive line count with hysteresis in both directions
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || !kill_armed) begin
      kill_cnt <= 7'h00;
      killed   <= 1'b0;
    end else if (LINE_I) begin
      if (below != killed) begin
        kill_cnt <= kill_cnt + 7'h01;
        if (kill_cnt == cgk_pkg::KILL_LAST_LINE) begin
          killed <= !killed;
        end
      end else begin
        kill_cnt <= 7'h00;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      COLOR_KILLED_O <= 1'b0;
    end else begin
      COLOR_KILLED_O <= killed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain scaling and neutral substitution
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      gained <= '0;
    end else begin
      gained.valid <= SAMPLE_I.valid;
      if (killed) begin
        gained.data <= 10'sh000;
      end else begin
        gained.data <= cgk_pkg::sat10(
          (24'(SAMPLE_I.data) * 24'($signed({1'b0, chroma_gain_active})))
          >>> cgk_pkg::GAIN_FRAC);
      end
    end
  end

  cgk_edge_sharpen u_sharpen (
    .clk_i   (CLK_I),
    .rst_n_i (RST_N_I),
    .en_i    (chroma_edge_sharpen_enable),
    .thr_i   (sharpen_thr),
    .in_i    (gained),
    .out_o   (SAMPLE_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_manual_gain_used: assert property (
    chroma_gain_mode == cgk_pkg::MODE_MANUAL
    |=> chroma_gain_active == $past(chroma_gain_manual))
    else $error("manual mode does not use the manual gain");
  chk_luma_gain_used: assert property (
    chroma_gain_mode == cgk_pkg::MODE_LUMA
    |=> chroma_gain_active == $past(LUMA_GAIN_I))
    else $error("luma mode does not follow luma gain");
  chk_loop_held: assert property (
    chroma_gain_mode != cgk_pkg::MODE_AUTO ##1
    chroma_gain_mode != cgk_pkg::MODE_AUTO |-> $stable(auto_gain))
    else $error("loop gain moved outside burst tracking");
  chk_gain_readback: assert property (
    RD_I && ADDR_I == cgk_pkg::ADDR_GAIN_LO
    |=> RDATA_O == $past(chroma_gain_active[7:0]))
    else $error("gain read does not show the active gain");
  chk_kill_after_lines: assert property (
    kill_armed && !killed && LINE_I && below
    && kill_cnt == cgk_pkg::KILL_LAST_LINE ##1 kill_armed |-> killed)
    else $error("colour not killed after the full line count");
  chk_kill_not_early: assert property (
    LINE_I && kill_cnt != cgk_pkg::KILL_LAST_LINE
    ##1 kill_armed |-> $stable(killed))
    else $error("kill state changed before the full line count");
  chk_component_no_kill: assert property (
    is_comp |=> !killed)
    else $error("component input was colour killed");
  chk_kill_enable_off: assert property (
    !color_suppress_enable |=> !killed ##1 !COLOR_KILLED_O)
    else $error("kill active while disabled");
  chk_neutral_output: assert property (
    killed && SAMPLE_I.valid |=> gained.valid && gained.data == 10'sh000)
    else $error("killed colour is not neutral");

  cov_kill_entered: cover property (!killed ##1 killed);
  cov_kill_restored: cover property (killed ##1 !killed);
  cov_auto_step: cover property (step_en && amp_seen != agc_target);
endmodule

// >>> sim/cgk_video_src.sv
// video source model: line pulses with burst and amplitude, steady samples
`timescale 1ns/1ns
module cgk_video_src #(
  parameter int LINE_CYC = 4
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // scene set by the bench
  input  wire logic signed [9:0] samp_i,
  input  wire logic [9:0]        burst_i,
  input  wire logic [9:0]        amp_i,
  // digitized video
  output cgk_pkg::cgk_samp_t     samp_o,
  output logic                   line_o,
  output logic [9:0]             burst_o,
  output logic [9:0]             amp_o
);
  int cnt;
  // one line pulse every LINE_CYC cycles
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || cnt == LINE_CYC - 1) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign line_o = rst_n_i && cnt == LINE_CYC - 1;
  // measurements only hold with the pulse, inverted between pulses
  assign burst_o = line_o ? burst_i : ~burst_i;
  assign amp_o   = line_o ? amp_i : ~amp_i;
  assign samp_o  = '{valid: 1'b1, data: samp_i};
endmodule

// >>> sim/cgk_chroma_ctrl_tb.sv
// self-checking bench of the chroma gain and colour kill block
`timescale 1ns/1ns
module cgk_chroma_ctrl_tb;
  logic CLK_I, RST_N_I, wr, rd, line;
  logic [7:0] addr, wdata, rdata;
  logic signed [9:0] samp;
  logic [9:0] burst, amp, bpct, camp, lt, ct, st;
  logic [11:0] luma;
  logic [1:0] fmt;
  cgk_pkg::cgk_samp_t si, so;
  logic killed;
  int checked, miscompares;
  logic [9:0] qam_thr [7] = '{10'h005, 10'h00f, 10'h019, 10'h028, 10'h055,
    10'h0a0, 10'h140};
  logic [9:0] fm_thr [7] = '{10'h000, 10'h032, 10'h046, 10'h050, 10'h05f,
    10'h096, 10'h140};
  logic [7:0] ra [9] = '{8'h01, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h3d, 8'h4d,
    8'h4e, 8'h77};
  logic [7:0] rv [9] = '{8'h00, 8'h40, 8'h02, 8'hc4, 8'h00, 8'h40, 8'h00,
    8'h08, 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  // clock
  always #4 CLK_I = ~CLK_I;

  cgk_video_src src (.clk_i(CLK_I), .rst_n_i(RST_N_I), .samp_i(samp),
    .burst_i(burst), .amp_i(amp), .samp_o(si), .line_o(line),
    .burst_o(bpct), .amp_o(camp));
  cgk_chroma_ctrl #(.SLOW_CYC(8), .MED_CYC(4), .FAST_CYC(2)) DUT (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SAMPLE_I(si), .LINE_I(line),
    .BURST_PCT_I(bpct), .CHROMA_AMP_I(camp), .LUMA_GAIN_I(luma),
    .INPUT_FMT_I(fmt), .SAMPLE_O(so), .COLOR_KILLED_O(killed),
    .LUMA_TARGET_O(lt), .CDIFF_TARGET_O(ct), .SYNC_TARGET_O(st));

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] e, g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge CLK_I);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLK_I);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_I);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK_I);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic get_gain(output logic [11:0] g);
    logic [7:0] h, l;
    rd_reg(8'h2d, h);
    rd_reg(8'h2e, l);
    g = {h[3:0], l};
  endtask
  task automatic wait_lines(input int n);
    int seen, lim;
    seen = 0;
    lim = 0;
    while (seen < n) begin
      @(negedge CLK_I);
      if (line === 1'b1) seen++;
      lim++;
      if (lim > n * 8 + 16) begin
        miscompares++;
        $display("mismatch line wait expected %0d seen %0d", n, seen);
        finish_test();
      end
    end
  endtask
  task automatic step_chk(input logic signed [9:0] a, b, e);
    samp <= a;
    repeat (4) @(posedge CLK_I);
    samp <= b;
    repeat (2) @(posedge CLK_I);
    #1 chk("edge sample", e, so.data);
  endtask
  task automatic loop_delta(input logic [7:0] spd, output int dl);
    logic [11:0] a, b;
    wr_reg(8'h2d, spd);
    get_gain(a);
    repeat (40) @(posedge CLK_I);
    get_gain(b);
    dl = int'(b) - int'(a);
  endtask
  task automatic kill_case(input logic [1:0] f, input logic [2:0] code,
                           input logic [9:0] b, input logic e);
    fmt <= f;
    burst <= b;
    wr_reg(8'h3d, {1'b0, code, 4'h0});
    wr_reg(8'h2b, 8'h00);
    wr_reg(8'h2b, 8'h40);
    wait_lines(126);
    chk("killed early", 12'h000, {11'h0, killed});
    wait_lines(3);
    repeat (2) @(posedge CLK_I);
    chk("killed", {11'h0, e}, {11'h0, killed});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd_reg(ra[i], d);
      chk("reset value", {4'h0, rv[i]}, {4'h0, d});
    end
    rd_reg(8'h2b, d);
    @(posedge CLK_I);
    #1 chk("read idle", 12'h000, {4'h0, rdata});
    $display("test reset done");
  endtask
  task automatic t_level();
    wr_reg(8'h01, 8'h20);
    repeat (2) @(posedge CLK_I);
    chk("luma target", 12'h2ca, {2'h0, lt});
    chk("cdiff target", 12'h1d3, {2'h0, ct});
    chk("sync target", 12'h11e, {2'h0, st});
    wr_reg(8'h01, 8'h00);
    repeat (2) @(posedge CLK_I);
    chk("std targets", 12'h2bc, {2'h0, lt});
    chk("std cdiff", 12'h15e, {2'h0, ct});
    chk("std sync", 12'h12c, {2'h0, st});
    $display("test level done");
  endtask
  task automatic t_gain();
    logic [11:0] g;
    wr_reg(8'h2c, 8'h00);
    wr_reg(8'h2d, 8'hc8);
    get_gain(g);
    chk("manual gain", 12'h800, g);
    repeat (4) @(posedge CLK_I);
    chk("doubled", 12'h0c8, {2'h0, so.data});
    chk("sample valid", 12'h001, {11'h0, so.valid});
    wr_reg(8'h2d, 8'hcf);
    wr_reg(8'h2e, 8'hff);
    samp <= 10'sh12c;
    repeat (4) @(posedge CLK_I);
    chk("sat high", 12'h1ff, {2'h0, so.data});
    samp <= 10'sh2d4;
    repeat (4) @(posedge CLK_I);
    chk("sat low", 12'h200, {2'h0, so.data});
    wr_reg(8'h2d, 8'hc4);
    wr_reg(8'h2e, 8'h00);
    wr_reg(8'h2c, 8'h01);
    get_gain(g);
    chk("luma gain", 12'h300, g);
    wr_reg(8'h2c, 8'h00);
    $display("test gain done");
  endtask
  task automatic t_sharp();
    step_chk(10'sh000, 10'sh064, 10'sh064);
    wr_reg(8'h4d, 8'h01);
    step_chk(10'sh000, 10'sh064, 10'sh096);
    @(posedge CLK_I);
    #1 chk("settled", 12'h064, {2'h0, so.data});
    @(posedge CLK_I);
    step_chk(10'sh064, 10'sh068, 10'sh068);
    wr_reg(8'h4d, 8'h00);
    samp <= 10'sh064;
    $display("test sharpen done");
  endtask
  task automatic t_loop();
    int d;
    wr_reg(8'h2c, 8'h02);
    amp <= 10'h000;
    loop_delta(8'h84, d);
    chk("fast steps", 12'h001, 12'(d >= 15));
    loop_delta(8'h44, d);
    chk("medium steps", 12'h001, 12'(d >= 9 && d <= 13));
    loop_delta(8'hc4, d);
    chk("adaptive steps", 12'h001, 12'(d >= 15));
    loop_delta(8'h04, d);
    chk("slow steps", 12'h001, 12'(d >= 2 && d <= 8));
    wr_reg(8'h2c, 8'h03);
    loop_delta(8'h84, d);
    chk("frozen", 12'h000, 12'(d));
    wr_reg(8'h2c, 8'h00);
    loop_delta(8'h84, d);
    chk("manual steady", 12'h000, 12'(d));
    @(posedge CLK_I);
    amp <= 10'h096;
    $display("test loop done");
  endtask
  task automatic t_kill();
    kill_case(cgk_pkg::FMT_QAM, 3'h4, 10'h054, 1'b1);
    #1 chk("neutral", 12'h000, {2'h0, so.data});
    @(posedge CLK_I);
    burst <= 10'h3e8;
    wait_lines(126);
    chk("still killed", 12'h001, {11'h0, killed});
    wait_lines(3);
    repeat (2) @(posedge CLK_I);
    chk("restored", 12'h000, {11'h0, killed});
    kill_case(cgk_pkg::FMT_QAM, 3'h6, 10'h000, 1'b1);
    wr_reg(8'h2b, 8'h00);
    repeat (3) @(posedge CLK_I);
    chk("kill off", 12'h000, {11'h0, killed});
    kill_case(cgk_pkg::FMT_COMP, 3'h6, 10'h000, 1'b0);
    kill_case(cgk_pkg::FMT_QAM, 3'h4, 10'h055, 1'b0);
    for (int i = 0; i < 7; i++) begin
      kill_case(cgk_pkg::FMT_QAM, 3'(i), qam_thr[i] - 10'h001, 1'b1);
      kill_case(cgk_pkg::FMT_FM, 3'(i), (i == 0) ? 10'h000 :
        fm_thr[i] - 10'h001, 1'(i != 0));
    end
    $display("test kill done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    CLK_I = 1'b0;
    RST_N_I = 1'b0;
    {addr, wdata, wr, rd} = '0;
    samp = 10'sh064;
    burst = 10'h3e8;
    amp = 10'h096;
    luma = 12'h300;
    fmt = cgk_pkg::FMT_QAM;
    checked = 0;
    miscompares = 0;
    repeat (12) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    t_reset();
    t_level();
    t_gain();
    t_sharp();
    t_loop();
    t_kill();
    finish_test();
  end
endmodule
